// ---- include/sps_pkg.sv ----
// Shared constants for the pipelined synchronous SRAM port
package sps_pkg;
  localparam int ADDR_W_DEF    = 17;   // 128K words of 18 bits
  localparam int DATA_W_DEF    = 18;
  localparam int LANES_DEF     = 2;
  localparam int BURST_CNT_W   = 2;    // Burst counter width, four accesses
  localparam int BURST_LEN     = 4;
  localparam int WRITE_LAT     = 2;    // Write data follows the address by this many cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [BURST_CNT_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_CNT_W-1:0] BURST_ONE  = 2'h1;
endpackage : sps_pkg

// ---- hw/sps_burst.sv ----
// Two-bit burst address generator, linear or interleaved order
`timescale 1ns/1ps
module sps_burst
  import sps_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   step_en,
  input  wire logic                   load,
  input  wire logic [BURST_CNT_W-1:0] seed,
  input  wire logic                   order_linear,
  output logic      [BURST_CNT_W-1:0] addr_lo
);
  logic [BURST_CNT_W-1:0] base_q;
  logic [BURST_CNT_W-1:0] cnt_q;
  wire  [BURST_CNT_W-1:0] base_d = load ? seed : base_q;
  wire  [BURST_CNT_W-1:0] cnt_d  = load ? BURST_ZERO : cnt_q + BURST_ONE;

  // Counter width makes the access after the fourth wrap to the base
  assign addr_lo = order_linear ? base_d + cnt_d : base_d ^ cnt_d;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= BURST_ZERO;
      cnt_q  <= BURST_ZERO;
    end else if (step_en) begin
      base_q <= base_d;
      cnt_q  <= cnt_d;
    end
  end
endmodule : sps_burst

// ---- hw/sps_mem.sv ----
// Byte-lane writable storage array with registered read data
`timescale 1ns/1ps
module sps_mem #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 18,
  parameter int LANES  = 2
) (
  input  wire logic              clk_sys,
  input  wire logic              wr_en,
  input  wire logic [LANES-1:0]  wr_lanes,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  localparam int LANE_W = DATA_W / LANES;
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
    for (int i = 0; i < LANES; i++) begin
      if (wr_en && wr_lanes[i]) begin
        mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
      end
    end
  end
endmodule : sps_mem

// ---- hw/sps_port.sv ----
// Pipelined synchronous SRAM port, device side
`timescale 1ns/1ps
module sps_port
  import sps_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int LANES  = LANES_DEF
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] address_inputs,
  input  wire logic              chip_enable_n,
  input  wire logic              depth_enable_low,
  input  wire logic              depth_enable_high,
  input  wire logic              advance_or_load,
  input  wire logic              read_write_n,
  input  wire logic              clock_enable_n,
  input  wire logic [LANES-1:0]  byte_write_en_n,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              output_enable_n,
  input  wire logic              snooze_enable,
  input  wire logic              linear_burst_order_n,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe
);
  localparam int LANE_W = DATA_W / LANES;

  // Cycle decode
  wire step_en  = ~clock_enable_n & ~snooze_enable;
  wire load     = ~advance_or_load;
  wire sel_in   = ~chip_enable_n & ~depth_enable_low & depth_enable_high;

  logic              last_sel_q;
  logic              last_write_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic              a_valid_q;
  logic              a_write_q;
  logic [ADDR_W-1:0] a_addr_q;
  logic [LANES-1:0]  a_lanes_q;
  logic              b_valid_q;
  logic              b_write_q;
  logic [ADDR_W-1:0] b_addr_q;
  logic [LANES-1:0]  b_lanes_q;
  logic              fwd_q;
  logic [LANES-1:0]  fwd_lanes_q;
  logic [DATA_W-1:0] fwd_data_q;
  logic              drive_q;
  logic [DATA_W-1:0] data_out_q;
  logic [DATA_W-1:0] rd_data;
  logic [BURST_CNT_W-1:0] burst_lo;

  // Type and select only change on a load; advance keeps the prior ones
  wire cur_valid = load ? sel_in : last_sel_q;
  wire cur_write = load ? ~read_write_n : last_write_q;
  wire [ADDR_W-BURST_CNT_W-1:0] cur_hi =
    load ? address_inputs[ADDR_W-1:BURST_CNT_W] : last_addr_q[ADDR_W-1:BURST_CNT_W];
  wire [ADDR_W-1:0] cur_addr = {cur_hi, burst_lo};
  // Lane mask active for any write cycle, selected or not
  wire [LANES-1:0] cur_lanes = cur_write ? ~byte_write_en_n : '0;

  sps_burst u_burst (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .step_en      (step_en),
    .load         (load),
    .seed         (address_inputs[BURST_CNT_W-1:0]),
    .order_linear (~linear_burst_order_n),
    .addr_lo      (burst_lo)
  );

  // Memory side strobes
  wire wr_now  = step_en & b_valid_q & b_write_q;
  wire rd_now  = step_en & a_valid_q & ~a_write_q;
  wire collide = rd_now & wr_now & (a_addr_q == b_addr_q);

  sps_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .LANES  (LANES)
  ) u_mem (
    .clk_sys  (clk_sys),
    .wr_en    (wr_now),
    .wr_lanes (b_lanes_q),
    .wr_addr  (b_addr_q),
    .wr_data  (data_in),
    .rd_en    (rd_now),
    .rd_addr  (a_addr_q),
    .rd_data  (rd_data)
  );

  // Late write to the same word wins over stale array data
  logic [DATA_W-1:0] merged;
  always_comb begin
    merged = rd_data;
    for (int i = 0; i < LANES; i++) begin
      if (fwd_q && fwd_lanes_q[i]) begin
        merged[i*LANE_W +: LANE_W] = fwd_data_q[i*LANE_W +: LANE_W];
      end
    end
  end

  // Burst context of the last loaded cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      last_sel_q   <= 1'b0;
      last_write_q <= 1'b0;
      last_addr_q  <= '0;
    end else if (step_en) begin
      last_sel_q   <= cur_valid;
      last_write_q <= cur_write;
      last_addr_q  <= cur_addr;
    end
  end

  // First pipeline stage: captured command
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      a_valid_q <= 1'b0;
      a_write_q <= 1'b0;
      a_addr_q  <= '0;
      a_lanes_q <= '0;
    end else if (step_en) begin
      a_valid_q <= cur_valid;
      a_write_q <= cur_write;
      a_addr_q  <= cur_addr;
      a_lanes_q <= cur_lanes;
    end
  end

  // Second stage: array read data returns, write commits with its data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      b_valid_q   <= 1'b0;
      b_write_q   <= 1'b0;
      b_addr_q    <= '0;
      b_lanes_q   <= '0;
      fwd_q       <= 1'b0;
      fwd_lanes_q <= '0;
      fwd_data_q  <= '0;
    end else if (step_en) begin
      b_valid_q   <= a_valid_q;
      b_write_q   <= a_write_q;
      b_addr_q    <= a_addr_q;
      b_lanes_q   <= a_lanes_q;
      fwd_q       <= collide;
      fwd_lanes_q <= b_lanes_q;
      fwd_data_q  <= data_in;
    end
  end

  // Output register: read data comes one cycle later than write data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      drive_q    <= 1'b0;
      data_out_q <= '0;
    end else if (step_en) begin
      drive_q <= b_valid_q & ~b_write_q;
      if (b_valid_q && !b_write_q) begin
        data_out_q <= merged;
      end
    end
  end

  assign data_out = data_out_q;
  // Output drivers follow the enable with no clock involved
  assign data_oe  = drive_q & ~output_enable_n & ~snooze_enable;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence wr_load_s;
    step_en && load && sel_in && !read_write_n;
  endsequence
  sequence rd_load_s;
    step_en && load && sel_in && read_write_n;
  endsequence
  sequence two_steps_s;
    step_en [*2];
  endsequence

  write_latency_a : assert property (wr_load_s ##1 two_steps_s |-> wr_now)
    else $error("write not committed two cycles after address");
  read_latency_a : assert property (rd_load_s ##1 two_steps_s |=>
                                    data_oe || output_enable_n || snooze_enable)
    else $error("read data not driven at pipeline latency");
  clock_hold_a : assert property (!step_en |=> $stable(a_addr_q) && $stable(data_out_q))
    else $error("state moved while clock disabled");
  snooze_hold_a : assert property (snooze_enable |=> $stable(a_valid_q) && $stable(drive_q))
    else $error("state moved during snooze");
  oe_gate_a : assert property (output_enable_n || snooze_enable |-> !data_oe)
    else $error("drivers on while output disabled");
  deselect_a : assert property (step_en && load && chip_enable_n |=> !a_valid_q)
    else $error("selected with chip enable inactive");
  rw_ignored_a : assert property (step_en && !load |=> a_write_q == $past(last_write_q))
    else $error("cycle type changed on advance");
  seed_bits_a : assert property (step_en && load |=> a_addr_q == $past(address_inputs))
    else $error("loaded address not captured");
  read_lanes_a : assert property (step_en && load && read_write_n |=> a_lanes_q == '0)
    else $error("lane enable active on read");
  burst_wrap_a : assert property (step_en && load ##1 (step_en && !load) [*4] |=>
                                  a_addr_q == $past(a_addr_q, 4))
    else $error("burst did not wrap after fourth access");
endmodule : sps_port

// ---- testbench/sps_ctrl_model.sv ----
// Memory controller model for the synchronous SRAM port
`timescale 1ns/1ps
module sps_ctrl_model
  import sps_pkg::*;
(
  output logic [ADDR_W_DEF-1:0] address_inputs,
  output logic                  chip_enable_n,
  output logic                  depth_enable_low,
  output logic                  depth_enable_high,
  output logic                  advance_or_load,
  output logic                  read_write_n,
  output logic                  clock_enable_n,
  output logic [LANES_DEF-1:0]  byte_write_en_n,
  output logic [DATA_W_DEF-1:0] data_in,
  output logic                  snooze_enable
);
  logic [DATA_W_DEF:0] wq [2] = '{default: '0};

  // One step; bus shows junk unless write data is due
  task automatic issue(input logic adv, input logic wr, input int sel,
                       input logic [ADDR_W_DEF-1:0] a, input logic [LANES_DEF-1:0] be_n,
                       input logic [DATA_W_DEF-1:0] d);
    clock_enable_n    = 1'b0;
    snooze_enable     = 1'b0;
    advance_or_load   = adv;
    read_write_n      = adv ? wr : !wr;
    address_inputs    = adv ? ~a : a;
    chip_enable_n     = adv | (sel == 1);
    depth_enable_low  = adv | (sel == 2);
    depth_enable_high = !adv & (sel != 3);
    byte_write_en_n   = be_n;
    data_in           = wq[1][DATA_W_DEF] ? wq[1][DATA_W_DEF-1:0] : ~data_in;
    wq[1]             = wq[0];
    wq[0]             = {wr, d};
  endtask : issue

  // Stretched or snoozed cycle carrying a stray write load
  task automatic hold(input logic zz);
    clock_enable_n    = !zz;
    snooze_enable     = zz;
    advance_or_load   = 1'b0;
    read_write_n      = 1'b0;
    chip_enable_n     = 1'b0;
    depth_enable_low  = 1'b0;
    depth_enable_high = 1'b1;
    data_in           = ~data_in;
  endtask : hold

  initial begin
    data_in         = '0;
    address_inputs  = '0;
    byte_write_en_n = '1;
    hold(1'b0);
  end
endmodule : sps_ctrl_model

// ---- testbench/sps_port_test.sv ----
// Self-checking bench for the pipelined synchronous SRAM port
`timescale 1ns/1ps
module sps_port_test;
  import sps_pkg::*;
  localparam int LW = DATA_W_DEF / LANES_DEF;
  logic                  clk_sys = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  output_enable_n = 1'b0;
  logic                  linear_burst_order_n = 1'b0;
  logic [ADDR_W_DEF-1:0] address_inputs;
  logic                  chip_enable_n, depth_enable_low, depth_enable_high, advance_or_load;
  logic                  read_write_n, clock_enable_n, snooze_enable, data_oe;
  logic [LANES_DEF-1:0]  byte_write_en_n;
  logic [DATA_W_DEF-1:0] data_in, data_out;
  logic [DATA_W_DEF-1:0] exp_m [16];
  logic [DATA_W_DEF:0]   ex [3];
  int                    fails = 0;
  int                    checked = 0;

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  sps_port sps_port_i (
    .clk_sys, .reset_n, .address_inputs, .chip_enable_n, .depth_enable_low, .depth_enable_high,
    .advance_or_load, .read_write_n, .clock_enable_n, .byte_write_en_n, .data_in,
    .output_enable_n, .snooze_enable, .linear_burst_order_n, .data_out, .data_oe);
  sps_ctrl_model sps_ctrl_model_i (
    .address_inputs, .chip_enable_n, .depth_enable_low, .depth_enable_high, .advance_or_load,
    .read_write_n, .clock_enable_n, .byte_write_en_n, .data_in, .snooze_enable);

  task automatic compare(input logic [DATA_W_DEF-1:0] got, input logic [DATA_W_DEF-1:0] want);
    checked++;
    if (got !== want) begin
      fails++;
      $display("FAIL t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : compare

  task automatic compare_bit(input logic got, input logic want);
    checked++;
    if (got !== want) begin
      fails++;
      $display("FAIL t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : compare_bit

  task automatic conclude;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // One step; kind 0 idle, 1 write, 2 read; judges the read loaded three steps back
  task automatic op(input logic adv, input int kind, input int sel,
                    input logic [ADDR_W_DEF-1:0] a, input logic [LANES_DEF-1:0] be_n,
                    input logic [DATA_W_DEF-1:0] d);
    @(negedge clk_sys);
    sps_ctrl_model_i.issue(adv, kind == 1, sel, a, be_n, d);
    #1;
    compare_bit(data_oe, ex[2][DATA_W_DEF] & ~output_enable_n);
    if (ex[2][DATA_W_DEF]) compare(data_out, ex[2][DATA_W_DEF-1:0]);
    ex[2] = ex[1];
    ex[1] = ex[0];
    ex[0] = {kind == 2 && sel == 0, exp_m[a[3:0]]};
    if (kind == 1 && sel == 0)
      for (int i = 0; i < LANES_DEF; i++)
        if (!be_n[i]) exp_m[a[3:0]][i*LW +: LW] = d[i*LW +: LW];
  endtask : op

  task automatic flush;
    repeat (3) op(0, 0, 1, 17'h0, 2'h3, 18'h0);
  endtask : flush

  task automatic freeze(input logic zz, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      sps_ctrl_model_i.hold(zz);
      #1 if (zz) compare_bit(data_oe, 1'b0);
    end
  endtask : freeze

  task automatic restart(input logic order_n);
    @(negedge clk_sys);
    reset_n = 1'b0;
    linear_burst_order_n = order_n;
    ex = '{default: '0};
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
  endtask : restart

  task automatic s_lanes;
    op(0, 1, 0, 17'h0, 2'h0, 18'h2A5C3);
    op(0, 1, 0, 17'h1, 2'h0, 18'h15A3C);
    op(0, 2, 0, 17'h0, 2'h0, 18'h0);
    op(0, 1, 0, 17'h1, 2'h2, 18'h3FF00);
    op(0, 2, 0, 17'h1, 2'h0, 18'h0);
    op(0, 1, 0, 17'h0, 2'h1, 18'h3FFFF);
    op(0, 2, 0, 17'h0, 2'h0, 18'h0);
    flush;
  endtask : s_lanes

  task automatic s_deselect;
    op(0, 1, 0, 17'h4, 2'h0, 18'h0A5A5);
    for (int s = 1; s < 4; s++) begin
      op(0, 1, s, 17'h4, 2'h0, 18'h3C3C3);
      op(0, 2, s, 17'h4, 2'h0, 18'h0);
    end
    op(0, 2, 0, 17'h4, 2'h0, 18'h0);
    flush;
  endtask : s_deselect

  task automatic s_stall;
    op(0, 2, 0, 17'h0, 2'h3, 18'h0);
    freeze(0, 3);
    op(0, 1, 0, 17'h5, 2'h0, 18'h12345);
    freeze(0, 2);
    op(0, 2, 0, 17'h5, 2'h0, 18'h0);
    flush;
  endtask : s_stall

  task automatic s_snooze;
    op(0, 2, 0, 17'h1, 2'h3, 18'h0);
    op(0, 2, 0, 17'h0, 2'h3, 18'h0);
    op(0, 0, 1, 17'h0, 2'h3, 18'h0);
    freeze(1, 3);
    op(0, 2, 0, 17'h0, 2'h3, 18'h0);
    flush;
  endtask : s_snooze

  task automatic s_oe;
    op(0, 2, 0, 17'h0, 2'h3, 18'h0);
    op(0, 0, 1, 17'h0, 2'h3, 18'h0);
    op(0, 0, 1, 17'h0, 2'h3, 18'h0);
    output_enable_n = 1'b1;
    op(0, 0, 1, 17'h0, 2'h3, 18'h0);
    output_enable_n = 1'b0;
    flush;
  endtask : s_oe

  // Burst write, plain reads, then burst read over the same four words
  task automatic s_burst(input logic order_n, input logic [1:0] b);
    logic [ADDR_W_DEF-1:0] a;
    restart(order_n);
    for (int k = 0; k < 13; k++) begin
      a = {15'h2, order_n ? b ^ k[1:0] : b + k[1:0]};
      if (k / 4 == 1) a = {15'h2, k[1:0]};
      op(k / 4 != 1 && (k % 4 != 0 || k == 12), k < 4 ? 1 : 2, 0, a, 2'h0,
         {16'h4000, k[1:0]});
    end
    flush;
  endtask : s_burst

  initial begin
    restart(1'b0);
    s_lanes;
    s_deselect;
    s_stall;
    s_snooze;
    s_oe;
    s_burst(1'b0, 2'h2);
    s_burst(1'b1, 2'h1);
    conclude;
  end

  initial begin
    #(CLK_PERIOD_NS * 20000);
    fails++;
    conclude;
  end
endmodule : sps_port_test
